// ### design/pb_reset_regs.vh
// Constants for the push-button reset timer: variants, timing, states.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PB_RESET_REGS_VH
`define PB_RESET_REGS_VH

// ----------------------------------------------------------------------
// Behaviour variants
// ----------------------------------------------------------------------
`define VAR_SINGLE_FIXED   2'h0
`define VAR_DUAL_FIXED     2'h1
`define VAR_DUAL_LEVEL     2'h2

// ----------------------------------------------------------------------
// Timing figures (ms) and clock rate
// ----------------------------------------------------------------------
`define CLK_HZ             25000000
`define CYC_PER_MS         25000
`define HOLD_LONG_MS       7500
`define HOLD_ALT_MS        12500
`define PULSE_MS           400
`define HOLD_MIN_MS        6000
`define PULSE_MIN_MS       320
`define CNT_W              32
`define CNT_ONE            32'h00000001
`define CNT_ZERO           32'h00000000
`define TS_WIN_CYC         2'h3
`define TS_WIN_ONE         2'h1
`define TS_WIN_ZERO        2'h0

// ----------------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------------
`define ST_IDLE            2'h0
`define ST_HOLD            2'h1
`define ST_PULSE           2'h2
`define ST_WAIT_REL        2'h3

`endif

// ### design/pb_sync2.v
// Two-flop synchroniser for asynchronous pin levels.
// Assumes one clock; first stage is read only by the second.
`timescale 1ns/1ns
`default_nettype none

module pb_sync2 #(
  parameter RST_VAL = 1'b1
) (
  input  wire core_clk,   // Core clock
  input  wire srst,       // Sync reset, high
  input  wire d_async,    // Raw pin level
  output reg  q_r         // Synchronised level
);

  reg meta_r;

  // ----------------------------------------------------------------------
  // Two-stage capture
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= d_async;
      q_r    <= meta_r;
    end
  end

endmodule // pb_sync2

`default_nettype wire

// ### design/push_button_reset_timer.v
// Push-button reset timer: waits for buttons held low for a long delay, then
// drives an active-low open-drain reset. Assumes buttons and select
// are asynchronous pins and that the board supplies the pull-ups.
`timescale 1ns/1ns
`default_nettype none
`include "pb_reset_regs.vh"

module push_button_reset_timer #(
  parameter [1:0]          VARIANT     = `VAR_DUAL_FIXED,
  parameter [`CNT_W-1:0]   HOLD_SEL0   = `HOLD_LONG_MS * `CYC_PER_MS,
  parameter [`CNT_W-1:0]   HOLD_SEL1   = `HOLD_ALT_MS * `CYC_PER_MS,
  parameter [`CNT_W-1:0]   PULSE_CYC   = `PULSE_MS * `CYC_PER_MS
) (
  input  wire core_clk,      // 25 MHz core clock
  input  wire srst,          // Sync reset, active high
  input  wire button_in_a,   // Button A, active low, async
  input  wire button_in_b,   // Button B, active low, async
  input  wire timer_select,  // Hold delay strap, async
  output wire rst_out,       // Open-drain output level (always 0)
  output reg  rst_oe_n_r,    // Low while driving reset low
  output reg  rst_active_r   // Reset asserted, active high
);

  // ----------------------------------------------------------------------
  // Sequencer state codes
  // ----------------------------------------------------------------------
  // Shortened hold and pulse counts are for simulation only
  localparam [1:0] S_IDLE     = `ST_IDLE;
  localparam [1:0] S_HOLD     = `ST_HOLD;
  localparam [1:0] S_PULSE    = `ST_PULSE;
  localparam [1:0] S_WAIT_REL = `ST_WAIT_REL;

  wire a_s;
  wire b_s;
  wire ts_s;
  wire ts_win_open;
  wire pulse_nxt;

  reg [1:0]         state_r;
  reg [1:0]         state_nxt;
  reg [`CNT_W-1:0]  cnt_r;
  reg [`CNT_W-1:0]  cnt_nxt;
  reg               ts_r;
  reg               ts_nxt;
  reg [1:0]         ts_win_r;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  pb_sync2 #(.RST_VAL(1'b1)) u_sync_a (
    .core_clk (core_clk),
    .srst     (srst),
    .d_async  (button_in_a),
    .q_r      (a_s)
  );

  pb_sync2 #(.RST_VAL(1'b1)) u_sync_b (
    .core_clk (core_clk),
    .srst     (srst),
    .d_async  (button_in_b),
    .q_r      (b_s)
  );

  pb_sync2 #(.RST_VAL(1'b0)) u_sync_ts (
    .core_clk (core_clk),
    .srst     (srst),
    .d_async  (timer_select),
    .q_r      (ts_s)
  );

  // Qualifying low: single variant watches A only
  function cond_low;
    input [1:0] var_sel;
    input       a;
    input       b;
    begin
      if (var_sel == `VAR_SINGLE_FIXED)
        cond_low = ~a;
      else
        cond_low = ~a & ~b;
    end
  endfunction

  // Hold delay chosen from latched select
  function [`CNT_W-1:0] hold_cyc;
    input sel;
    begin
      hold_cyc = sel ? HOLD_SEL1 : HOLD_SEL0;
    end
  endfunction

  // Counter step, shared by hold and pulse timing
  function [`CNT_W-1:0] cnt_inc;
    input [`CNT_W-1:0] cnt;
    begin
      cnt_inc = cnt + `CNT_ONE;
    end
  endfunction

  wire low_now = cond_low(VARIANT, a_s, b_s);

  // Power-up capture window still open
  assign ts_win_open = (ts_win_r != `TS_WIN_ZERO);

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ts_nxt    = ts_r;
    // select sampled while released or at start
    if (!low_now || ts_win_open)
      ts_nxt = ts_s;
    case (state_r)
      S_IDLE: begin
        cnt_nxt = `CNT_ZERO;
        if (low_now)
          state_nxt = S_HOLD;
      end
      S_HOLD: begin
        if (!low_now) begin
          state_nxt = S_IDLE;
          cnt_nxt   = `CNT_ZERO;
        end else if (cnt_inc(cnt_r) >= hold_cyc(ts_r)) begin
          state_nxt = S_PULSE;
          cnt_nxt   = `CNT_ZERO;
        end else begin
          cnt_nxt = cnt_inc(cnt_r);
        end
      end
      S_PULSE: begin
        if (VARIANT == `VAR_DUAL_LEVEL) begin
          if (!low_now)
            state_nxt = S_IDLE;
        end else begin
          if (cnt_inc(cnt_r) >= PULSE_CYC) begin
            state_nxt = S_WAIT_REL;
            cnt_nxt   = `CNT_ZERO;
          end else begin
            cnt_nxt = cnt_inc(cnt_r);
          end
        end
      end
      S_WAIT_REL: begin
        cnt_nxt = `CNT_ZERO;
        if (!low_now)
          state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
        cnt_nxt   = `CNT_ZERO;
      end
    endcase
  end

  // Reset pin is driven for the whole pulse state
  assign pulse_nxt = (state_nxt == S_PULSE);

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      state_r <= S_IDLE;
      cnt_r   <= `CNT_ZERO;
      ts_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ts_r    <= ts_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Power-up select window
  // ----------------------------------------------------------------------
  // Open until the select synchroniser has flushed its reset value; a
  // shorter window would latch that reset value rather than the strap
  // whenever the buttons are already down when reset lifts
  // power-up select capture
  always @(posedge core_clk) begin
    if (srst) begin
      ts_win_r <= `TS_WIN_CYC;
    end else if (ts_win_open) begin
      ts_win_r <= ts_win_r - `TS_WIN_ONE;
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  // Taken from the next state so the pin moves on the same edge as the
  // sequencer, straight out of a flip-flop and free of decode glitches
  always @(posedge core_clk) begin
    if (srst) begin
      rst_oe_n_r   <= 1'b1;
      rst_active_r <= 1'b0;
    end else begin
      rst_oe_n_r   <= ~pulse_nxt;
      rst_active_r <= pulse_nxt;
    end
  end

  // Open drain only ever pulls low; the pull-up gives the high level
  assign rst_out = 1'b0;

endmodule // push_button_reset_timer

`default_nettype wire

// ### verif/pb_reset_monitor.sv
// Port checker for the push-button reset timer.
// Assumes one clock and srst sync high.
`timescale 1ns/1ns
`default_nettype none
module pb_reset_monitor #(
  parameter [1:0]  VARIANT   = 2'h1,
  parameter [31:0] HOLD_SEL0 = 32'h14,
  parameter [31:0] HOLD_SEL1 = 32'h1E,
  parameter [31:0] PULSE_CYC = 32'h8
) (
  input wire logic core_clk,     // Clock
  input wire logic srst,         // Reset
  input wire logic button_in_a,  // Button A
  input wire logic button_in_b,  // Button B
  input wire logic timer_select, // Strap
  input wire logic rst_out,      // Pin data
  input wire logic rst_oe_n_r,   // Drive enable
  input wire logic rst_active_r  // Asserted
);
  logic [31:0] lo_r;  // Cycles asserted
  logic [31:0] dn_r;  // Cycles held low
  logic [2:0]  age_r; // Cycles since release
  logic        arm_r; // Release since pulse
  wire  logic  up = button_in_a | (button_in_b & (VARIANT != 2'h0));
  // Fixed pulses hide input moves
  wire  logic  up_ok = up & (~rst_active_r | (VARIANT == 2'h2));
  wire  logic [31:0] hold = timer_select ? HOLD_SEL1 : HOLD_SEL0;
  // Helper counters
  always @(posedge core_clk) begin
    if (srst) begin
      lo_r <= 32'h0;
      dn_r <= 32'h0;
      age_r <= 3'h7;
      arm_r <= 1'b1;
    end else begin
      lo_r <= rst_active_r ? lo_r + 32'h1 : 32'h0;
      dn_r <= up_ok ? 32'h0 : dn_r + 32'h1;
      age_r <= up ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
      arm_r <= up_ok | (arm_r & ~$fell(rst_oe_n_r));
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  out_pair_a:
    assert property (rst_active_r == ~rst_oe_n_r) else $error("flags disagree");
  drive_zero_a:
    assert property (rst_out == 1'b0) else $error("pin data not low");
  pulse_width_a:
    assert property (VARIANT != 2'h2 && $rose(rst_oe_n_r) |-> lo_r == PULSE_CYC)
      else $error("pulse width");
  hold_min_a:
    assert property ($fell(rst_oe_n_r) |-> dn_r >= hold) else $error("reset too early");
  hold_max_a:
    assert property (dn_r == hold + 8 |-> !arm_r) else $error("reset too late");
  one_pulse_a:
    assert property ($fell(rst_oe_n_r) |-> arm_r) else $error("second pulse");
  level_rel_a:
    assert property (VARIANT == 2'h2 && rst_active_r && up |-> ##[1:6] rst_oe_n_r)
      else $error("level not released");
  level_why_a:
    assert property (VARIANT == 2'h2 && $rose(rst_oe_n_r) |-> age_r < 3'h7)
      else $error("release without cause");
  cover property ($fell(rst_oe_n_r));
  cover property (timer_select && $fell(rst_oe_n_r));
  cover property (VARIANT == 2'h2 && $rose(rst_oe_n_r));
endmodule // pb_reset_monitor
bind push_button_reset_timer pb_reset_monitor #(.VARIANT(VARIANT), .HOLD_SEL0(HOLD_SEL0),
  .HOLD_SEL1(HOLD_SEL1), .PULSE_CYC(PULSE_CYC)) u_pb_reset_monitor (.core_clk(core_clk),
  .srst(srst), .button_in_a(button_in_a), .button_in_b(button_in_b),
  .timer_select(timer_select), .rst_out(rst_out), .rst_oe_n_r(rst_oe_n_r),
  .rst_active_r(rst_active_r));
`default_nettype wire

// ### verif/pb_far_side.sv
// Far side: pulled-up reset line and toggling latch.
// Assumes a clear pulse while power ramps.
`timescale 1ns/1ns
`default_nettype none
module pb_far_side (
  input  wire logic rst_out,    // Pin data
  input  wire logic rst_oe_n_r, // Low while driven
  input  wire logic rc_clr,     // Power-up clear
  output wire logic sys_rst_n,  // Line level
  output var  logic latch_q     // Latched reset
);
  // Pull-up holds the line when released
  assign sys_rst_n = rst_oe_n_r ? 1'b1 : rst_out;
  always @(posedge sys_rst_n or posedge rc_clr) begin
    if (rc_clr)
      latch_q <= 1'b0;
    else
      latch_q <= ~latch_q;
  end
endmodule // pb_far_side
`default_nettype wire

// ### verif/push_button_reset_timer_test.sv
// Bench: three variants share the buttons.
// Assumes short sim counts for hold and pulse.
`timescale 1ns/1ns
`default_nettype none
module push_button_reset_timer_test;
  localparam int H0 = 20;
  localparam int H1 = 30;
  localparam int PW = 8;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic button_in_a = 1'b1;
  logic button_in_b = 1'b1;
  logic timer_select = 1'b0;
  logic rc_clr = 1'b1;
  wire logic [2:0] r_out, oe_n, act;
  wire logic sys_rst_n, latch_q;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  int t;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  for (genvar g = 0; g < 3; g++) begin : g_var
    push_button_reset_timer #(.VARIANT(2'(g)), .HOLD_SEL0(H0), .HOLD_SEL1(H1),
      .PULSE_CYC(PW)) u_push_button_reset_timer (.core_clk(core_clk), .srst(srst),
      .button_in_a(button_in_a), .button_in_b(button_in_b), .timer_select(timer_select),
      .rst_out(r_out[g]), .rst_oe_n_r(oe_n[g]), .rst_active_r(act[g]));
  end
  pb_far_side u_pb_far_side (.rst_out(r_out[0]), .rst_oe_n_r(oe_n[0]), .rc_clr(rc_clr),
    .sys_rst_n(sys_rst_n), .latch_q(latch_q));
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic wait_fall();
    t = 0;
    while (oe_n[1] !== 1'b0 && t < 60) begin
      wt(1);
      t++;
    end
  endtask
  // Broken hold restarts the count
  task automatic t_short();
    button_in_a = 1'b0;
    button_in_b = 1'b0;
    wt(H0 - 5);
    button_in_a = 1'b1;
    wt(1);
    button_in_a = 1'b0;
    wt(H0 - 5);
    chk("short", oe_n, 3'h7);
    button_in_a = 1'b1;
    button_in_b = 1'b1;
    wt(10);
  endtask
  // Glitch inside fixed pulses; level one releases
  task automatic t_fixed();
    button_in_a = 1'b0;
    button_in_b = 1'b0;
    wait_fall();
    chk("hold", t >= H0 && t <= H0 + 8, 1'b1);
    wt(1);
    button_in_a = 1'b1;
    wt(1);
    button_in_a = 1'b0;
    wt(PW - 3);
    chk("pulse", oe_n[1:0], 2'h0);
    chk("act_pulse", act[1:0], 2'h3);
    wt(1);
    chk("end", oe_n, 3'h7);
    wt(40);
    chk("again", oe_n, 3'h3);
    chk("act_again", act, 3'h4);
    button_in_a = 1'b1;
    wt(8);
    chk("release", oe_n, 3'h7);
    chk("latch", latch_q, 1'b1);
  endtask
  // Strap picks the long hold; B tied low
  task automatic t_select();
    button_in_b = 1'b0;
    timer_select = 1'b1;
    wt(4);
    button_in_a = 1'b0;
    wait_fall();
    chk("sel", t >= H1 && t <= H1 + 8, 1'b1);
    wt(PW + 1);
    chk("toggle", latch_q, 1'b0);
    button_in_a = 1'b1;
    wt(8);
  endtask
  initial begin
    wt(2);
    srst = 1'b0;
    rc_clr = 1'b0;
    t_short();
    t_fixed();
    t_select();
    report_and_stop();
  end
endmodule // push_button_reset_timer_test
`default_nettype wire
